// ==== umc_pkg.sv ====
// Purpose: shared constants and types for the serial mode/interrupt configuration block
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes:   status and mask registers share one bit layout

package umc_pkg;

  // register byte offsets
  localparam logic [7:0]  UMC_OFS_MODE   = 8'h04;
  localparam logic [7:0]  UMC_OFS_IER    = 8'h08;
  localparam logic [7:0]  UMC_OFS_IDR    = 8'h0c;
  localparam logic [7:0]  UMC_OFS_IMR    = 8'h10;
  localparam logic [7:0]  UMC_OFS_STAT   = 8'h14;
  localparam logic [7:0]  UMC_OFS_BRG    = 8'h20;

  // writable bits and reset values
  localparam logic [31:0] UMC_MODE_WMASK = 32'h173fffff;
  localparam logic [31:0] UMC_MODE_RST   = 32'h00000000;
  localparam logic [19:0] UMC_IRQ_MASK   = 20'hf3fff;
  localparam logic [19:0] UMC_IMR_RST    = 20'h00000;
  localparam logic [19:0] UMC_STAT_RST   = 20'h00000;
  localparam logic [15:0] UMC_BRG_RST    = 16'h0000;

  // status bit positions of events the block raises itself
  localparam int          UMC_ST_PARITY_ERROR_FLAG    = 7;
  localparam int          UMC_ST_ITER    = 10;
  localparam int          UMC_ST_NEGATIVE_ACK    = 13;
  localparam int          UMC_ST_MODEM   = 16;

  // line protocol codes
  localparam logic [3:0]  UMC_PROTO_NORMAL = 4'h0;
  localparam logic [3:0]  UMC_PROTO_RS485  = 4'h1;
  localparam logic [3:0]  UMC_PROTO_HWHS   = 4'h2;
  localparam logic [3:0]  UMC_PROTO_MODEM  = 4'h3;
  localparam logic [3:0]  UMC_PROTO_ISO_T0 = 4'h4;
  localparam logic [3:0]  UMC_PROTO_ISO_T1 = 4'h6;
  localparam logic [3:0]  UMC_PROTO_IRDA   = 4'h8;

  // clock source codes
  localparam logic [1:0]  UMC_CLK_MASTER = 2'h0;
  localparam logic [1:0]  UMC_CLK_DIV    = 2'h1;
  localparam logic [1:0]  UMC_CLK_EXT    = 2'h3;

  // loop mode codes
  localparam logic [1:0]  UMC_LOOP_NORMAL = 2'h0;
  localparam logic [1:0]  UMC_LOOP_ECHO   = 2'h1;
  localparam logic [1:0]  UMC_LOOP_LOCAL  = 2'h2;
  localparam logic [1:0]  UMC_LOOP_REMOTE = 2'h3;

  // check bit type codes
  localparam logic [2:0]  UMC_PAR_EVEN  = 3'h0;
  localparam logic [2:0]  UMC_PAR_ODD   = 3'h1;
  localparam logic [2:0]  UMC_PAR_SPACE = 3'h2;
  localparam logic [2:0]  UMC_PAR_MARK  = 3'h3;

  // clock counts
  localparam logic [7:0]  UMC_PRESCALE  = 8'h08;
  localparam logic [3:0]  UMC_OVS16_TOP = 4'hf;
  localparam logic [3:0]  UMC_OVS8_TOP  = 4'h7;

  // mode configuration register layout
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       rx_filter;
    logic       rsv_27;
    logic [2:0] max_repeat;
    logic [1:0] rsv_23;
    logic       negative_ack_repeat_limit_enable;
    logic       negative_ack_inhibit;
    logic       over8;
    logic       clock_pin_drive;
    logic       nine_bit_select;
    logic       bit_order_select;
    logic [1:0] channel_loop_mode;
    logic [1:0] stop_bit_count;
    logic [2:0] check_bit_type;
    logic       sync_mode;
    logic [1:0] char_width;
    logic [1:0] clock_source_select;
    logic [3:0] line_mode;
  } umc_mode_t;

  // decoded configuration handed to the shifters
  typedef struct packed {
    logic [3:0] proto;
    logic       reserved;
    logic       sync_mode;
    logic [3:0] char_bits;
    logic       par_en;
    logic       multidrop;
    logic [2:0] stop_halves;
    logic       msb_first;
    logic       over8;
  } umc_cfg_t;

endpackage : umc_pkg

// ==== umc_rx_filter.sv ====
// Purpose: optional two-of-three majority filter on the receive line
// Assumes: tick_in is one sixteenth of a bit period, or one eighth when over8 is set
// Notes:   output is registered; idle line level is high
`timescale 1ns/1ps

module umc_rx_filter
  import umc_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // control
  input  wire logic filt_en_in,
  input  wire logic tick_in,
  // line
  input  wire logic line_in,
  output logic      line_out
);

  logic [2:0] smp_r;
  logic       maj;

  // three-sample history taken at the sample tick
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      smp_r <= 3'h7;
    end else if (tick_in) begin
      smp_r <= {smp_r[1:0], line_in};
    end
  end

  assign maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);

  // filtered or straight line; filtering adds latency, so off unless asked
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      line_out <= 1'b1;
    end else begin
      line_out <= filt_en_in ? maj : line_in; // RULE14
    end
  end

  property p_filt_pass;
    @(posedge clk_in) disable iff (!nrst_in)
      !filt_en_in |=> line_out == $past(line_in);
  endproperty
  a_filt_pass: assert property (p_filt_pass) else $error("unfiltered line not passed through"); // RULE14

endmodule : umc_rx_filter

// ==== umc_core.sv ====
// Purpose: mode configuration and interrupt enable logic of a serial transceiver
// Assumes: Avalon-MM slave with waitrequest, byte addresses, one wait state
// Notes:   shifters sit outside; this block decodes, clocks, routes and flags
//
// Overview of operation
// RULE1: a four-bit field picks the line protocol; unlisted codes are reserved.
// RULE2: baud source is master, prescaled master or clock pin; pin driven selectively.
// RULE3: character width is 5 to 8 bits, or 9 with nine-bit select.
// RULE4: clocked mode bit 0 means asynchronous, 1 means synchronous.
// RULE5: parity is even, odd, space, mark, none or multi-drop.
// RULE6: stop bits 1, 1.5 or 2; 1.5 reserved when synchronous; 11 reserved.
// RULE7: loop mode selects normal, echo, local loopback or remote loopback.
// RULE8: bit order select chooses LSB or MSB first both ways.
// RULE9: each bit is oversampled by 16, or by 8 when selected.
// RULE10: inhibit bit suppresses negative acknowledge generation.
// RULE11: without repeat limit a parity error raises an immediate negative acknowledge.
// RULE12: with repeat limit, errors are counted; past the limit acknowledges stop, flag sets.
// RULE13: the repeat limit comes from its field, for smart-card T=0 mode.
// RULE14: smoothing bit enables a two-of-three receive filter at sixteenth bit rate; the filter samples at eighth bit rate when over8 is set.
// RULE15: writing one to enable register sets that mask bit; zero does nothing.
// RULE16: enable bits 0 to 19 cover the listed status sources.
// RULE17: writing one to disable register clears that mask bit; zero does nothing.
// RULE18: the mask register reads back which sources are enabled.
// RULE19: interrupt output is high while an enabled status flag is set.
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

module umc_core
  import umc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // register bus
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // interrupt
  output logic             irq_out,
  // status events from the shifters, one-cycle pulses
  input  wire logic [19:0] events_in,
  // serial pins
  input  wire logic        rxd_in,
  output logic             txd_out,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  input  wire logic [3:0]  modem_in,
  output logic             negative_ack_out,
  // shifter side
  output umc_cfg_t         cfg_out,
  output logic             sample_tick_out,
  output logic             bit_tick_out,
  input  wire logic        tx_bit_in,
  output logic             rx_bit_out,
  input  wire logic [8:0]  tx_char_in,
  input  wire logic        tx_addr_in,
  output logic [8:0]       tx_word_out,
  output logic             tx_parity_out,
  input  wire logic        rx_valid_in,
  input  wire logic [8:0]  rx_word_in,
  input  wire logic        rx_parity_in,
  output logic [8:0]       rx_char_out
);

  umc_mode_t   m;
  umc_cfg_t    cfg_nxt;
  logic        req, ack_r, wr_acc;
  logic [31:0] mode_r;
  logic [19:0] imr_r, status_r, ev, wd_m;
  logic [15:0] brg_r, baud_cnt_r;
  logic [7:0]  pre_cnt_r;
  logic [3:0]  ovs_cnt_r, ovs_top;
  logic [3:0]  modem_d_r;
  logic        modem_vld_r, sck_d_r, src_tick, pre_tick;
  logic        rxd_filt, iso_t0, perr, rep_hit, iter_ev;
  logic [2:0]  rep_cnt_r;
  logic [8:0]  tx_ord, rx_ord;

  assign m = umc_mode_t'(mode_r);

  // bus handshake: one wait state, then the access is taken
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign wr_acc              = avs_write_in & ack_r;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read data is prepared in the wait cycle so it stands at the taking edge
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~ack_r) begin
      unique case (avs_address_in)
        UMC_OFS_MODE: avs_readdata_out <= mode_r;
        UMC_OFS_IMR:  avs_readdata_out <= {12'h000, imr_r}; // RULE18
        UMC_OFS_STAT: avs_readdata_out <= {12'h000, status_r};
        UMC_OFS_BRG:  avs_readdata_out <= {16'h0000, brg_r};
        default:      avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // configuration registers; reserved bits never store
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      mode_r <= UMC_MODE_RST;
      brg_r  <= UMC_BRG_RST;
    end else if (wr_acc) begin
      if (avs_address_in == UMC_OFS_MODE) begin
        mode_r <= avs_writedata_in & UMC_MODE_WMASK;
      end
      if (avs_address_in == UMC_OFS_BRG) begin
        brg_r <= avs_writedata_in[15:0];
      end
    end
  end

  // mask: set-only and clear-only ports so bits can be changed one at a time
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      imr_r <= UMC_IMR_RST;
    end else if (wr_acc && avs_address_in == UMC_OFS_IER) begin
      imr_r <= imr_r | (avs_writedata_in[19:0] & UMC_IRQ_MASK); // RULE15 RULE16
    end else if (wr_acc && avs_address_in == UMC_OFS_IDR) begin
      imr_r <= imr_r & ~(avs_writedata_in[19:0] & UMC_IRQ_MASK); // RULE17
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      status_r <= UMC_STAT_RST;
    end else if (wr_acc && avs_address_in == UMC_OFS_STAT) begin
      status_r <= (status_r & ~avs_writedata_in[19:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  // registered interrupt level
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_r & imr_r); // RULE19
    end
  end

  // decode of the mode configuration
  always_comb begin
    cfg_nxt           = '0;
    cfg_nxt.proto     = m.line_mode; // RULE1
    cfg_nxt.reserved  = (m.line_mode == 4'h5) || (m.line_mode == 4'h7) ||
                        (m.line_mode > UMC_PROTO_IRDA) || (m.clock_source_select == 2'h2) ||
                        (m.stop_bit_count == 2'h3) ||
                        (m.sync_mode && m.stop_bit_count == 2'h1); // RULE1 RULE6
    cfg_nxt.sync_mode = m.sync_mode; // RULE4
    cfg_nxt.char_bits = m.nine_bit_select ? 4'h9 : 4'h5 + {2'h0, m.char_width}; // RULE3
    cfg_nxt.par_en    = !(m.check_bit_type[2] && !m.check_bit_type[1]); // RULE5
    cfg_nxt.multidrop = m.check_bit_type[2] && m.check_bit_type[1]; // RULE5
    unique case (m.stop_bit_count)
      2'h1:    cfg_nxt.stop_halves = 3'h3; // RULE6
      2'h2:    cfg_nxt.stop_halves = 3'h4;
      default: cfg_nxt.stop_halves = 3'h2;
    endcase
    cfg_nxt.msb_first = m.bit_order_select; // RULE8
    cfg_nxt.over8     = m.over8;
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= cfg_nxt;
    end
  end

  // fixed prescaler for the divided master clock source
  assign pre_tick = (pre_cnt_r == UMC_PRESCALE - 8'h01);

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pre_cnt_r <= 8'h00;
      sck_d_r   <= 1'b0;
    end else begin
      pre_cnt_r <= pre_tick ? 8'h00 : pre_cnt_r + 8'h01;
      sck_d_r   <= sck_in;
    end
  end

  // source tick: every cycle, prescaled, or rising edge of the clock pin
  always_comb begin
    unique case (m.clock_source_select)
      UMC_CLK_MASTER: src_tick = 1'b1; // RULE2
      UMC_CLK_DIV:    src_tick = pre_tick;
      UMC_CLK_EXT:    src_tick = sck_in & ~sck_d_r;
      default:        src_tick = 1'b0;
    endcase
  end

  // baud divider; a zero divisor stops the sample clock
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      baud_cnt_r      <= 16'h0000;
      sample_tick_out <= 1'b0;
    end else begin
      sample_tick_out <= 1'b0;
      if (src_tick && brg_r != 16'h0000) begin
        if (baud_cnt_r >= brg_r - 16'h0001) begin
          baud_cnt_r      <= 16'h0000;
          sample_tick_out <= 1'b1;
        end else begin
          baud_cnt_r <= baud_cnt_r + 16'h0001;
        end
      end
    end
  end

  // oversampling counter gives one bit tick per 16 or 8 samples
  assign ovs_top = m.over8 ? UMC_OVS8_TOP : UMC_OVS16_TOP; // RULE9

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ovs_cnt_r    <= 4'h0;
      bit_tick_out <= 1'b0;
    end else begin
      bit_tick_out <= 1'b0;
      if (sample_tick_out) begin
        if (ovs_cnt_r >= ovs_top) begin
          ovs_cnt_r    <= 4'h0;
          bit_tick_out <= 1'b1; // RULE9
        end else begin
          ovs_cnt_r <= ovs_cnt_r + 4'h1;
        end
      end
    end
  end

  // clock pin: high for the first half of each bit; never fights an external clock
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sck_out    <= 1'b0;
      sck_oe_out <= 1'b0;
    end else begin
      sck_out    <= m.over8 ? ~ovs_cnt_r[2] : ~ovs_cnt_r[3];
      sck_oe_out <= m.clock_pin_drive && (m.clock_source_select != UMC_CLK_EXT); // RULE2
    end
  end

  umc_rx_filter u_rx_filter (
    .clk_in     (core_clk_in),
    .nrst_in    (nrst_in),
    .filt_en_in (m.rx_filter),
    .tick_in    (sample_tick_out),
    .line_in    (rxd_in),
    .line_out   (rxd_filt)
  ); // RULE14

  // channel routing; local loopback parks the pin at idle high
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      txd_out    <= 1'b1;
      rx_bit_out <= 1'b1;
    end else begin
      unique case (m.channel_loop_mode)
        UMC_LOOP_NORMAL: begin
          txd_out    <= tx_bit_in;
          rx_bit_out <= rxd_filt;
        end
        UMC_LOOP_ECHO: begin
          txd_out    <= rxd_filt; // RULE7
          rx_bit_out <= rxd_filt;
        end
        UMC_LOOP_LOCAL: begin
          txd_out    <= 1'b1; // RULE7
          rx_bit_out <= tx_bit_in;
        end
        UMC_LOOP_REMOTE: begin
          txd_out    <= rxd_filt; // RULE7
          rx_bit_out <= 1'b1;
        end
      endcase
    end
  end

  // per-bit reorder within the character width; bits above it read zero
  for (genvar i = 0; i < 9; i++) begin : g_order
    assign tx_ord[i] = (4'(i) >= cfg_out.char_bits) ? 1'b0 :
                       cfg_out.msb_first ? tx_char_in[cfg_out.char_bits - 4'h1 - 4'(i)] :
                       tx_char_in[i]; // RULE8
    assign rx_ord[i] = (4'(i) >= cfg_out.char_bits) ? 1'b0 :
                       cfg_out.msb_first ? rx_word_in[cfg_out.char_bits - 4'h1 - 4'(i)] :
                       rx_word_in[i]; // RULE8
  end

  // parity of a masked word; order does not change the sum
  function automatic logic calc_par(input logic [8:0] d, input logic [2:0] t, input logic a);
    logic p;
    p = 1'b0;
    unique case (t)
      UMC_PAR_EVEN:  p = ^d;
      UMC_PAR_ODD:   p = ~^d;
      UMC_PAR_SPACE: p = 1'b0;
      UMC_PAR_MARK:  p = 1'b1;
      default:       p = a;
    endcase
    return p;
  endfunction : calc_par

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      tx_word_out   <= 9'h000;
      tx_parity_out <= 1'b0;
      rx_char_out   <= 9'h000;
    end else begin
      tx_word_out   <= tx_ord;
      tx_parity_out <= calc_par(tx_ord, m.check_bit_type, tx_addr_in); // RULE5
      if (rx_valid_in) begin
        rx_char_out <= rx_ord;
      end
    end
  end

  // receive check; multi-drop carries an address flag, so nothing to check
  assign perr = rx_valid_in && cfg_nxt.par_en && !cfg_nxt.multidrop &&
                (rx_parity_in != calc_par(rx_ord, m.check_bit_type, 1'b0)); // RULE5

  assign iso_t0  = (m.line_mode == UMC_PROTO_ISO_T0);
  assign rep_hit = (rep_cnt_r >= m.max_repeat); // RULE13
  assign iter_ev = iso_t0 && perr && m.negative_ack_repeat_limit_enable && rep_hit;

  // smart-card acknowledge; the count restarts on every clean character
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      negative_ack_out  <= 1'b0;
      rep_cnt_r <= 3'h0;
    end else begin
      negative_ack_out <= 1'b0;
      if (iso_t0 && rx_valid_in) begin
        if (!perr) begin
          rep_cnt_r <= 3'h0;
        end else if (!m.negative_ack_repeat_limit_enable) begin
          negative_ack_out <= !m.negative_ack_inhibit; // RULE10 RULE11
        end else if (!rep_hit) begin
          negative_ack_out  <= !m.negative_ack_inhibit; // RULE10 RULE12
          rep_cnt_r <= rep_cnt_r + 3'h1;
        end
      end
    end
  end

  // modem input change; first sample after reset is only a reference
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      modem_d_r   <= 4'h0;
      modem_vld_r <= 1'b0;
    end else begin
      modem_d_r   <= modem_in;
      modem_vld_r <= 1'b1;
    end
  end

  // event collection into the status layout
  always_comb begin
    ev                   = events_in & UMC_IRQ_MASK;
    ev[UMC_ST_PARITY_ERROR_FLAG]      = ev[UMC_ST_PARITY_ERROR_FLAG] | perr;
    ev[UMC_ST_ITER]      = ev[UMC_ST_ITER] | iter_ev; // RULE12
    ev[UMC_ST_NEGATIVE_ACK]      = ev[UMC_ST_NEGATIVE_ACK] | negative_ack_out;
    ev[UMC_ST_MODEM+:4]  = ev[UMC_ST_MODEM+:4] | ((modem_in ^ modem_d_r) & {4{modem_vld_r}});
  end

  // masked write data as a plain signal so the mask checks can look back at it
  assign wd_m = avs_writedata_in[19:0] & UMC_IRQ_MASK;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_irq;
    |(status_r & imr_r) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled status without interrupt"); // RULE19

  property p_ier;
    wr_acc && avs_address_in == UMC_OFS_IER |=>
      (imr_r & $past(wd_m)) == $past(wd_m) && (imr_r & $past(imr_r)) == $past(imr_r);
  endproperty
  a_ier: assert property (p_ier) else $error("enable write lost or cleared a bit"); // RULE15

  property p_idr;
    wr_acc && avs_address_in == UMC_OFS_IDR |=>
      (imr_r & $past(wd_m)) == 20'h00000 &&
      (imr_r | $past(wd_m)) == ($past(imr_r) | $past(wd_m));
  endproperty
  a_idr: assert property (p_idr) else $error("disable write wrong"); // RULE17

  property p_imr_read;
    avs_read_in && ack_r && avs_address_in == UMC_OFS_IMR |->
      avs_readdata_out == {12'h000, imr_r} && !avs_waitrequest_out;
  endproperty
  a_imr_read: assert property (p_imr_read) else $error("mask readback wrong"); // RULE18

  property p_sck_ext;
    m.clock_source_select == UMC_CLK_EXT |=> !sck_oe_out;
  endproperty
  a_sck_ext: assert property (p_sck_ext) else $error("clock pin driven on external clock"); // RULE2

  property p_nine;
    m.nine_bit_select |=> cfg_out.char_bits == 4'h9;
  endproperty
  a_nine: assert property (p_nine) else $error("nine-bit width not applied"); // RULE3

  property p_negative_ack_now;
    iso_t0 && perr && !m.negative_ack_repeat_limit_enable && !m.negative_ack_inhibit
      |=> negative_ack_out ##1 !negative_ack_out;
  endproperty
  a_negative_ack_now: assert property (p_negative_ack_now) else $error("immediate acknowledge missing"); // RULE11

  property p_inhibit;
    rx_valid_in && m.negative_ack_inhibit |=> !negative_ack_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited acknowledge sent"); // RULE10

  property p_limit;
    iso_t0 && perr && m.negative_ack_repeat_limit_enable && rep_hit
      |=> !negative_ack_out && status_r[UMC_ST_ITER];
  endproperty
  a_limit: assert property (p_limit) else $error("repeat limit not honoured"); // RULE12

  property p_local;
    m.channel_loop_mode == UMC_LOOP_LOCAL |=> txd_out;
  endproperty
  a_local: assert property (p_local) else $error("local loopback drives pin"); // RULE7

  c_negative_ack: cover property (negative_ack_out);
  c_iter: cover property (iter_ev);
  c_irq:  cover property (!irq_out ##1 irq_out);
  c_ier:  cover property (wr_acc && avs_address_in == UMC_OFS_IER);

endmodule : umc_core

// ==== umc_line_partner.sv ====
// Purpose: far-side line partner (card or modem) for the config block bench
// Assumes: the bench asks for line and modem levels
// Notes:   counts the negative acknowledge pulses the card sees
`timescale 1ns/1ps

module umc_line_partner (
  // clock
  input  wire logic       clk_in,
  // levels asked by the bench
  input  wire logic       line_lvl_in,
  input  wire logic [3:0] modem_lvl_in,
  // device pins
  input  wire logic       negative_ack_in,
  output logic            rxd_out,
  output logic [3:0]      modem_out,
  output logic            sck_out,
  output int              negative_ack_cnt_out
);
  // card and modem drive their lines from the asked level
  assign rxd_out   = line_lvl_in;
  assign modem_out = modem_lvl_in;
  // no synchronous frames here, so the serial clock stands still
  assign sck_out   = 1'b0;
  // count every acknowledge request seen on the card line
  initial negative_ack_cnt_out = 0;
  always @(posedge clk_in) if (negative_ack_in === 1'b1) negative_ack_cnt_out <= negative_ack_cnt_out + 1;
endmodule : umc_line_partner

// ==== tb.sv ====
// Purpose: self-checking bench for the mode and interrupt enable block
// Assumes: one wait cycle per bus access, partner model on the serial pins
// Notes:   settled outputs are checked at the falling edge; waitrequest, read data and bit ticks are sampled at the rising edge
`timescale 1ns/1ps

module tb
  import umc_pkg::*;
();
  logic        clk, nrst, rd, wr, wait_req, irq, txd, rxd, sck, negative_ack, rx_bit;
  logic        rx_valid, rx_par, tx_bit, line_lvl, btick;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [19:0] evts;
  logic [3:0]  modem, modem_lvl;
  logic [8:0]  rx_word, tx_word;
  logic        sck_oe;
  umc_cfg_t    cfg;
  int          failures, total_checks, negative_ack_cnt, n0;
  logic [1:0]  lp [4] = '{2'b10, 2'b00, 2'b11, 2'b01};

  umc_core dut (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .irq_out(irq),
    .events_in(evts), .rxd_in(rxd), .txd_out(txd), .sck_in(sck), .sck_out(),
    .sck_oe_out(sck_oe), .modem_in(modem), .negative_ack_out(negative_ack), .cfg_out(cfg),
    .sample_tick_out(), .bit_tick_out(btick), .tx_bit_in(tx_bit), .rx_bit_out(rx_bit),
    .tx_char_in(9'h001), .tx_addr_in(1'b0), .tx_word_out(tx_word), .tx_parity_out(),
    .rx_valid_in(rx_valid), .rx_word_in(rx_word), .rx_parity_in(rx_par),
    .rx_char_out());
  umc_line_partner card (.clk_in(clk), .line_lvl_in(line_lvl), .modem_lvl_in(modem_lvl),
    .negative_ack_in(negative_ack), .rxd_out(rxd), .modem_out(modem), .sck_out(sck),
    .negative_ack_cnt_out(negative_ack_cnt));

  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one bus access held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (wait_req !== 1'b0) failures++;
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rv);
  endtask : rchk

  // wait, then land on a falling edge so outputs are settled
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : ticks

  task automatic evt(input logic [19:0] e);
    @(posedge clk);
    evts <= e;
    @(posedge clk);
    evts <= 20'h0;
    ticks(3);
  endtask : evt

  task automatic card_char(input logic [8:0] w, input logic p);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_word <= w;
    rx_par <= p;
    @(posedge clk);
    rx_valid <= 1'b0;
    ticks(4);
  endtask : card_char

  task automatic results;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    {nrst, rd, wr, rx_valid, rx_par, line_lvl} = 6'h0;
    {tx_bit, addr, wdata, evts, modem_lvl, rx_word} = 74'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk("mode_rst", UMC_OFS_MODE, 32'h0);
    rchk("mask_rst", UMC_OFS_IMR, 32'h0);
    bus(1'b1, UMC_OFS_MODE, 32'hffffffff);
    rchk("mode_rw", UMC_OFS_MODE, UMC_MODE_WMASK);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, UMC_OFS_MODE, {28'h0, c[3:0]});
      ticks(1);
      chk("proto_rsv", {31'h0, !(c inside {0, 1, 2, 3, 4, 6, 8})}, {31'h0, cfg.reserved});
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, UMC_OFS_MODE, {12'h0, i[1], 1'b0, i == 4, i[0], 7'h0, i[0],
          (i < 4) ? i[1:0] : 2'h0, 6'h0});
      ticks(2);
      chk("width", {25'h0, 4'(5 + i), i[0], i[0], i[1]},
          {25'h0, cfg.char_bits, cfg.sync_mode, cfg.msb_first, cfg.over8});
      chk("order", {23'h0, i[0] ? 9'h001 << (4 + i) : 9'h001}, {23'h0, tx_word});
    end
    for (int p = 0; p < 8; p++) begin
      bus(1'b1, UMC_OFS_MODE, {18'h0, (p < 3) ? p[1:0] : 2'h0, p[2:0], 9'h0});
      ticks(1);
      chk("par_stop", {27'h0, !(p[2] & !p[1]), p[2] & p[1], 3'(2 + ((p < 3) ? p : 0))},
          {27'h0, cfg.par_en, cfg.multidrop, cfg.stop_halves});
    end
    bus(1'b1, UMC_OFS_MODE, 32'h00040000);
    ticks(2);
    chk("sck_drive", 32'h1, {31'h0, sck_oe});
    bus(1'b1, UMC_OFS_MODE, 32'h00040030);
    ticks(2);
    chk("sck_ext", 32'h0, {31'h0, sck_oe});
    @(posedge clk);
    tx_bit <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, UMC_OFS_MODE, {16'h0, m[1:0], 14'h0});
      ticks(4);
      chk("loop", {30'h0, lp[m]}, {30'h0, txd, rx_bit});
    end
    bus(1'b1, UMC_OFS_IER, 32'hffffffff);
    rchk("mask_set", UMC_OFS_IMR, {12'h0, UMC_IRQ_MASK});
    bus(1'b1, UMC_OFS_IDR, 32'h0000fffe);
    bus(1'b1, UMC_OFS_IER, 32'h0);
    rchk("mask_clr", UMC_OFS_IMR, 32'h000f0001);
    evt(20'h00002);
    chk("irq_masked", 32'h0, {31'h0, irq});
    evt(20'h00001);
    chk("irq_on", 32'h1, {31'h0, irq});
    rchk("status", UMC_OFS_STAT, 32'h3);
    bus(1'b1, UMC_OFS_STAT, 32'h3);
    ticks(2);
    chk("irq_off", 32'h0, {31'h0, irq});
    @(posedge clk);
    modem_lvl <= 4'h1;
    ticks(4);
    chk("irq_modem", 32'h1, {31'h0, irq});
    bus(1'b1, UMC_OFS_STAT, 32'hfffff);
    // divisor 1 gives a sample every cycle; count bit ticks over 64 cycles
    bus(1'b1, UMC_OFS_BRG, 32'h1);
    for (int v = 0; v < 2; v++) begin
      bus(1'b1, UMC_OFS_MODE, {12'h0, v[0], 19'h0});
      ticks(20);
      n0 = 0;
      repeat (64) begin
        @(posedge clk);
        n0 += btick;
      end
      chk("bit_tick", v[0] ? 32'h8 : 32'h4, n0);
    end
    // smart card, 8-bit even parity; a char with parity 0 and one set bit is bad
    bus(1'b1, UMC_OFS_MODE, 32'h000000c4);
    n0 = negative_ack_cnt;
    card_char(9'h001, 1'b1);
    card_char(9'h001, 1'b0);
    chk("negative_ack_now", n0 + 1, negative_ack_cnt);
    bus(1'b1, UMC_OFS_MODE, 32'h001000c4);
    card_char(9'h001, 1'b0);
    chk("negative_ack_inhibit", n0 + 1, negative_ack_cnt);
    bus(1'b1, UMC_OFS_STAT, 32'hfffff);
    bus(1'b1, UMC_OFS_MODE, 32'h022000c4);
    card_char(9'h001, 1'b1);
    repeat (3) card_char(9'h001, 1'b0);
    chk("negative_ack_limit", n0 + 3, negative_ack_cnt);
    rchk("repeat_flag", UMC_OFS_STAT, 32'h00002480);
    results();
  end
endmodule : tb
